// ---- include/lesr_pkg.sv ----
// Constants of the lane error status register group.
// Assumes a 32-bit bus with byte addresses; register index times four.
package lesr_pkg;
    // Lane and counter geometry
    localparam int MAX_LANES     = 32;
    localparam int LANES_PER_GRP = 8;
    localparam int CNT_W         = 4;
    localparam int CRC_W         = 32;
    localparam int DAT_W         = 32;
    localparam int SEL_W         = 4;
    localparam int ADR_W         = 8;
    localparam int IDX_W         = 6;
    localparam logic [CNT_W-1:0] CNT_SAT  = 4'hF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_LINK_RST = 6'h10;
    localparam logic [IDX_W-1:0] IDX_CNT0     = 6'h23;
    localparam logic [IDX_W-1:0] IDX_CNT1     = 6'h24;
    localparam logic [IDX_W-1:0] IDX_CNT2     = 6'h25;
    localparam logic [IDX_W-1:0] IDX_CNT3     = 6'h26;
    localparam logic [IDX_W-1:0] IDX_RX_FLAG  = 6'h28;
    localparam logic [IDX_W-1:0] IDX_TX_FLAG  = 6'h29;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h30;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 6'h31;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 6'h32;
    localparam logic [IDX_W-1:0] IDX_INJ      = 6'h38;

    // Link reset register bits and flag register bit
    localparam int RST_CNT_CLR_BIT = 6;
    localparam int RST_RXF_CLR_BIT = 8;
    localparam int RST_TXF_CLR_BIT = 9;
    localparam int FLAG_BIT        = 0;

    // Interrupt status layout
    localparam int IRQ_W   = 3;
    localparam int IRQ_CRC = 0;
    localparam int IRQ_RXF = 1;
    localparam int IRQ_TXF = 2;
endpackage

// ---- include/lesr_cnt_if.sv ----
// Carrier between the register group and its lane counter bank.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface lesr_cnt_if #(parameter int NUM_LANES = 24);
    logic [NUM_LANES-1:0]                  err;
    logic                                  clr;
    logic [NUM_LANES*lesr_pkg::CNT_W-1:0] cnt;
    modport owner (input err, input clr, output cnt);
    modport user  (output err, output clr, input cnt);
endinterface

// ---- rtl/lesr_lane_counters.sv ----
// Bank of saturating per-lane error counters.
// Assumes error strobes are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ns
module lesr_lane_counters #(
    parameter int NUM_LANES = 24
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Counter carrier
    lesr_cnt_if.owner cnt_if
);
    import lesr_pkg::*;

    logic [CNT_W-1:0] cnt_q [NUM_LANES];

    // Next count: clear, then count up, holding at the top
    function automatic logic [CNT_W-1:0] cnt_next(
        input logic [CNT_W-1:0] cur,
        input logic             err,
        input logic             clr
    );
        logic [CNT_W-1:0] res;
        res = cur;
        if (clr) begin
            res = err ? CNT_ONE : CNT_ZERO;
        end else if (err && cur != CNT_SAT) begin
            res = cur + CNT_ONE;
        end
        return res;
    endfunction

    // Counter update
    always_ff @(posedge clk_i) begin
        for (int l = 0; l < NUM_LANES; l++) begin
            if (rst_i) begin
                cnt_q[l] <= CNT_ZERO;
            end else begin
                cnt_q[l] <= cnt_next(cnt_q[l], cnt_if.err[l], cnt_if.clr); // RULE1 RULE2 RULE3
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Flatten counts and guard each lane
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        assign cnt_if.cnt[g*CNT_W +: CNT_W] = cnt_q[g];

        AST_CNT_INC: assert property ( // RULE1
            cnt_if.err[g] && !cnt_if.clr && cnt_q[g] != CNT_SAT
            |=> cnt_q[g] == CNT_W'($past(cnt_q[g]) + CNT_ONE))
            else $error("lane counter did not count an error");
        AST_CNT_SAT: assert property ( // RULE2
            cnt_q[g] == CNT_SAT && !cnt_if.clr |=> cnt_q[g] == CNT_SAT)
            else $error("lane counter left saturation");
        AST_CNT_CLR: assert property ( // RULE3
            cnt_if.clr && !cnt_if.err[g] |=> cnt_q[g] == CNT_ZERO)
            else $error("lane counter not cleared");
    end
endmodule

// ---- rtl/lesr_top.sv ----
// Lane error status and test register group on a classic Wishbone slave.
// Assumes event inputs are one-cycle or level strobes synchronous to clk_i.
`timescale 1ns/1ns

// Summary of operation
// RULE1 - Four-bit error counter per receive lane
// RULE2 - Counters stop at F, never wrap
// RULE3 - Reset register bit 6 zeroes counters
// RULE4 - Read-only groups for lanes 16-23, 24-31
// RULE5 - First group holds lanes 0-7, nibble each
// RULE6 - Sticky receive alignment-lost flag in bit 0
// RULE7 - Receive flag set on lane down faults
// RULE8 - Sticky transmit alignment-lost flag in bit 0
// RULE9 - Transmit flag set on FIFO under/overflow
// RULE10 - Flags cleared only by reset register
// RULE11 - Injection bit set corrupts lane checksum
// RULE12 - Injection bit clear sends correct checksum
// RULE13 - Software holds bit one metaframe minimum
// RULE14 - Held bit yields corrupted checksum on lane
// RULE15 - Groups ascend; absent lanes read zero
module lesr_top #(
    parameter int NUM_LANES = 24
) (
    // Clock and reset
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    // Wishbone slave
    input  wire logic                                   wb_cyc_i,
    input  wire logic                                   wb_stb_i,
    input  wire logic                                   wb_we_i,
    input  wire logic [lesr_pkg::ADR_W-1:0]             wb_adr_i,
    input  wire logic [lesr_pkg::SEL_W-1:0]             wb_sel_i,
    input  wire logic [lesr_pkg::DAT_W-1:0]             wb_dat_i,
    output logic      [lesr_pkg::DAT_W-1:0]             wb_dat_o,
    output logic                                        wb_ack_o,
    // Receive events
    input  wire logic [NUM_LANES-1:0]                   rx_crc_err_i,
    input  wire logic [NUM_LANES-1:0]                   rx_lane_down_i,
    input  wire logic                                   rx_align_fault_i,
    // Transmit events
    input  wire logic                                   tx_fifo_underflow_i,
    input  wire logic                                   tx_fifo_overflow_i,
    // Transmit checksum path
    input  wire logic [NUM_LANES*lesr_pkg::CRC_W-1:0]   tx_crc32_i,
    output logic      [NUM_LANES*lesr_pkg::CRC_W-1:0]   tx_crc32_o,
    // Interrupt
    output logic                                        irq_o
);
    import lesr_pkg::*;

    // Refuse lane counts the groups cannot hold
    if (NUM_LANES < 1 || NUM_LANES > MAX_LANES) begin : g_bad_lanes
        $error("NUM_LANES must lie between 1 and 32");
    end

    lesr_cnt_if #(.NUM_LANES(NUM_LANES)) cnt_if ();

    logic                 ack_q;
    logic [DAT_W-1:0]     rdat_q;
    logic [DAT_W-1:0]     rd_d;
    logic [NUM_LANES-1:0] inj_q;
    logic [IRQ_W-1:0]     irq_stat_q;
    logic [IRQ_W-1:0]     irq_en_q;
    logic [IRQ_W-1:0]     irq_set;
    logic [IRQ_W-1:0]     irq_clr;
    logic                 rxf_q;
    logic                 txf_q;
    logic                 rxf_set;
    logic                 txf_set;
    logic                 rxf_clr;
    logic                 txf_clr;
    logic                 bus_req;
    logic                 wr_go;
    logic                 rd_go;
    logic [IDX_W-1:0]     idx;
    logic [DAT_W-1:0]     wmask;
    logic                 rst_wr;

    // Expand byte enables into a bit mask
    function automatic logic [DAT_W-1:0] sel_mask(input logic [SEL_W-1:0] sel);
        logic [DAT_W-1:0] m;
        m = DAT_ZERO;
        for (int b = 0; b < SEL_W; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // Merge write data into a stored word under byte enables
    function automatic logic [DAT_W-1:0] merge(
        input logic [DAT_W-1:0] old,
        input logic [DAT_W-1:0] wdat,
        input logic [SEL_W-1:0] sel
    );
        logic [DAT_W-1:0] m;
        m = sel_mask(sel);
        return (old & ~m) | (wdat & m);
    endfunction

    // Pack one group of eight lane counters; absent lanes read zero
    function automatic logic [DAT_W-1:0] grp_word(
        input logic [NUM_LANES*CNT_W-1:0] cnt,
        input int                         grp
    );
        logic [DAT_W-1:0] w;
        int               lane;
        w = DAT_ZERO;
        for (int k = 0; k < LANES_PER_GRP; k++) begin
            lane = grp * LANES_PER_GRP + k;
            if (lane < NUM_LANES) begin
                w[k*CNT_W +: CNT_W] = cnt[lane*CNT_W +: CNT_W];
            end
        end
        return w;
    endfunction

    // Bus decode: one access per request, answered in the next cycle
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_go   = bus_req & wb_we_i;
    assign rd_go   = bus_req & ~wb_we_i;
    assign idx     = wb_adr_i[ADR_W-1:2];
    assign wmask   = wb_dat_i & sel_mask(wb_sel_i);
    assign rst_wr  = wr_go && idx == IDX_LINK_RST;

    // Clear pulses from the link reset register
    assign cnt_if.clr = rst_wr & wmask[RST_CNT_CLR_BIT]; // RULE3
    assign rxf_clr    = rst_wr & wmask[RST_RXF_CLR_BIT]; // RULE10
    assign txf_clr    = rst_wr & wmask[RST_TXF_CLR_BIT]; // RULE10

    // Counter events
    assign cnt_if.err = rx_crc_err_i; // RULE1

    lesr_lane_counters #(
        .NUM_LANES (NUM_LANES)
    ) u_counters (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cnt_if (cnt_if)
    );

    // Alignment-loss causes
    assign rxf_set = rx_align_fault_i | (|rx_lane_down_i);       // RULE7
    assign txf_set = tx_fifo_underflow_i | tx_fifo_overflow_i; // RULE9

    // Acknowledge one cycle after the request, drop the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // Read data register; zero outside the answer cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= DAT_ZERO;
        end else if (rd_go) begin
            rdat_q <= rd_d;
        end else begin
            rdat_q <= DAT_ZERO;
        end
    end

    // Read multiplexer; unmapped and write-only places read zero
    always_comb begin
        rd_d = DAT_ZERO;
        case (idx)
            IDX_CNT0: begin
                rd_d = grp_word(cnt_if.cnt, 0); // RULE5
            end
            IDX_CNT1: begin
                rd_d = grp_word(cnt_if.cnt, 1); // RULE15
            end
            IDX_CNT2: begin
                rd_d = grp_word(cnt_if.cnt, 2); // RULE4
            end
            IDX_CNT3: begin
                rd_d = grp_word(cnt_if.cnt, 3); // RULE4
            end
            IDX_RX_FLAG: begin
                rd_d[FLAG_BIT] = rxf_q; // RULE6
            end
            IDX_TX_FLAG: begin
                rd_d[FLAG_BIT] = txf_q; // RULE8
            end
            IDX_IRQ_STAT: begin
                rd_d[IRQ_W-1:0] = irq_stat_q;
            end
            IDX_IRQ_EN: begin
                rd_d[IRQ_W-1:0] = irq_en_q;
            end
            IDX_INJ: begin
                rd_d[NUM_LANES-1:0] = inj_q;
            end
            default: begin
                rd_d = DAT_ZERO;
            end
        endcase
    end

    // Sticky receive alignment-loss flag; set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxf_q <= 1'b0;
        end else begin
            rxf_q <= rxf_set | (rxf_q & ~rxf_clr); // RULE6 RULE10
        end
    end

    // Sticky transmit alignment-loss flag; set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txf_q <= 1'b0;
        end else begin
            txf_q <= txf_set | (txf_q & ~txf_clr); // RULE8 RULE10
        end
    end

    // Checksum corruption control word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inj_q <= '0;
        end else if (wr_go && idx == IDX_INJ) begin
            inj_q <= NUM_LANES'(merge(DAT_W'(inj_q), wb_dat_i, wb_sel_i)); // RULE11
        end
    end

    // Corrupt checksum words of lanes whose control bit is set
    always_ff @(posedge clk_i) begin
        for (int l = 0; l < NUM_LANES; l++) begin
            if (rst_i) begin
                tx_crc32_o[l*CRC_W +: CRC_W] <= '0;
            end else if (inj_q[l]) begin
                tx_crc32_o[l*CRC_W +: CRC_W] <= ~tx_crc32_i[l*CRC_W +: CRC_W]; // RULE11 RULE14
            end else begin
                tx_crc32_o[l*CRC_W +: CRC_W] <= tx_crc32_i[l*CRC_W +: CRC_W]; // RULE12
            end
        end
    end

    // Interrupt events and write-one-to-clear
    always_comb begin
        irq_set          = '0;
        irq_set[IRQ_CRC] = |rx_crc_err_i;
        irq_set[IRQ_RXF] = rxf_set;
        irq_set[IRQ_TXF] = txf_set;
        irq_clr          = '0;
        if (wr_go && idx == IDX_IRQ_CLR) begin
            irq_clr = wmask[IRQ_W-1:0];
        end
    end

    // Sticky interrupt status; set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= '0;
        end else if (wr_go && idx == IDX_IRQ_EN) begin
            irq_en_q <= IRQ_W'(merge(DAT_W'(irq_en_q), wb_dat_i, wb_sel_i));
        end
    end

    // Outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o    = |(irq_stat_q & irq_en_q);

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RD_GRP0: assert property ( // RULE5
        rd_go && idx == IDX_CNT0
        |=> wb_ack_o && wb_dat_o[CNT_W-1:0] == $past(cnt_if.cnt[CNT_W-1:0]))
        else $error("lane 0 count not read from first group");

    if (NUM_LANES > LANES_PER_GRP) begin : g_grp1
        AST_RD_GRP1: assert property ( // RULE15
            rd_go && idx == IDX_CNT1
            |=> wb_dat_o[CNT_W-1:0] == $past(cnt_if.cnt[LANES_PER_GRP*CNT_W +: CNT_W]))
            else $error("lane 8 count not read from second group");
    end

    if (NUM_LANES > 2 * LANES_PER_GRP) begin : g_grp2
        AST_RD_GRP2: assert property ( // RULE4
            rd_go && idx == IDX_CNT2
            |=> wb_dat_o[CNT_W-1:0] == $past(cnt_if.cnt[2*LANES_PER_GRP*CNT_W +: CNT_W]))
            else $error("lane 16 count not read from third group");
    end

    if (NUM_LANES <= 3 * LANES_PER_GRP) begin : g_grp3
        AST_RD_ABSENT: assert property ( // RULE15
            rd_go && idx == IDX_CNT3 |=> wb_ack_o && wb_dat_o == DAT_ZERO)
            else $error("absent lanes did not read zero");
    end

    AST_RXF_SET: assert property ( // RULE6 RULE7
        rxf_set |=> rxf_q ##1 (rxf_q || $past(rxf_clr)))
        else $error("receive alignment flag not set or not sticky");

    AST_RXF_HOLD: assert property ( // RULE10
        rxf_q && !rxf_clr |=> rxf_q)
        else $error("receive alignment flag fell without clear");

    AST_TXF_SET: assert property ( // RULE8 RULE9
        (tx_fifo_underflow_i || tx_fifo_overflow_i) |=> txf_q)
        else $error("transmit alignment flag not set");

    AST_TXF_HOLD: assert property ( // RULE10
        txf_q && !txf_clr |=> txf_q)
        else $error("transmit alignment flag fell without clear");

    AST_INJ_ON: assert property ( // RULE11 RULE14
        inj_q[0] |=> tx_crc32_o[CRC_W-1:0] == ~$past(tx_crc32_i[CRC_W-1:0]))
        else $error("lane 0 checksum not corrupted");

    // Sampled reset skips the release edge, where the output still reads zero
    AST_INJ_OFF: assert property ( // RULE12
        !rst_i && !inj_q[0] |=> tx_crc32_o[CRC_W-1:0] == $past(tx_crc32_i[CRC_W-1:0]))
        else $error("lane 0 checksum altered without injection");

    AST_RD_RXF: assert property ( // RULE6
        rd_go && idx == IDX_RX_FLAG |=> wb_dat_o == DAT_W'($past(rxf_q)))
        else $error("receive alignment flag misread");

    AST_RD_TXF: assert property ( // RULE8
        rd_go && idx == IDX_TX_FLAG |=> wb_dat_o == DAT_W'($past(txf_q)))
        else $error("transmit alignment flag misread");

    AST_RXF_DOWN: assert property ( // RULE7
        |rx_lane_down_i |=> rxf_q)
        else $error("lane down did not set receive alignment flag");

    AST_INJ_WR: assert property ( // RULE11
        wr_go && idx == IDX_INJ && &wb_sel_i |=> inj_q == $past(wb_dat_i[NUM_LANES-1:0]))
        else $error("checksum corruption control not written");

    AST_INJ_LAST: assert property ( // RULE11 RULE14
        inj_q[NUM_LANES-1]
        |=> tx_crc32_o[(NUM_LANES-1)*CRC_W +: CRC_W] == ~$past(tx_crc32_i[(NUM_LANES-1)*CRC_W +: CRC_W]))
        else $error("last lane checksum not corrupted");

    AST_ACK_NEXT: assert property (
        bus_req |=> wb_ack_o)
        else $error("request not answered in the next cycle");

    AST_DAT_IDLE: assert property (
        !rd_go |=> wb_dat_o == DAT_ZERO)
        else $error("read data not zero outside a read answer");

    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");
endmodule

// ---- tb/lesr_link_model.sv ----
// Far-side link model: sources lane checksums and flags lanes received altered.
// Assumes the block registers the checksum path with one cycle of delay.
`timescale 1ns/1ns
module lesr_link_model #(
    parameter int NUM_LANES = 24
) (
    // Clock and reset
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    // Checksum path
    input  wire logic [NUM_LANES*lesr_pkg::CRC_W-1:0] crc_rx_i,
    output logic      [NUM_LANES*lesr_pkg::CRC_W-1:0] crc_tx_o,
    output logic      [NUM_LANES-1:0]                 bad_o
);
    import lesr_pkg::*;
    logic [CRC_W-1:0]           seq_q;
    logic [NUM_LANES*CRC_W-1:0] sent_q;

    // Fresh pattern each cycle, distinct per lane, so a stale value never matches
    always_comb begin
        for (int l = 0; l < NUM_LANES; l++) begin
            crc_tx_o[l*CRC_W+:CRC_W] = ~seq_q ^ {seq_q[23:0], 8'(l)};
        end
    end

    // Compare what arrives against what was sent one cycle earlier
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_q  <= '0;
            sent_q <= '0;
            bad_o  <= '0;
        end else begin
            seq_q  <= seq_q + 32'h9E37_79B1;
            sent_q <= crc_tx_o;
            for (int l = 0; l < NUM_LANES; l++) begin
                bad_o[l] <= crc_rx_i[l*CRC_W+:CRC_W] !== sent_q[l*CRC_W+:CRC_W];
            end
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the lane error status register group.
// Assumes a one-clock design answering Wishbone requests with a one-cycle ack.
`timescale 1ns/1ns
module testbench;
    import lesr_pkg::*;
    localparam int NL = 24;
    logic                clk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                wb_cyc_i = 1'b0;
    logic                wb_stb_i = 1'b0;
    logic                wb_we_i = 1'b0;
    logic [ADR_W-1:0]    wb_adr_i = '0;
    logic [SEL_W-1:0]    wb_sel_i = '0;
    logic [DAT_W-1:0]    wb_dat_i = '0;
    logic [DAT_W-1:0]    wb_dat_o;
    logic                wb_ack_o;
    logic [NL-1:0]       rx_crc_err_i = '0;
    logic [NL-1:0]       rx_lane_down_i = '0;
    logic                rx_align_fault_i = 1'b0;
    logic                tx_fifo_underflow_i = 1'b0;
    logic                tx_fifo_overflow_i = 1'b0;
    logic [NL*CRC_W-1:0] tx_crc32_i;
    logic [NL*CRC_W-1:0] tx_crc32_o;
    logic                irq_o;
    logic [NL-1:0]       bad_lanes;
    logic [CNT_W-1:0]    exp_cnt [MAX_LANES];
    logic [DAT_W-1:0]    rd;
    logic [NL-1:0]       mask;
    logic [NL-1:0]       ends = NL'(1) | (NL'(1) << (NL - 1));
    logic [IDX_W-1:0]    regs [8] = '{IDX_CNT0, IDX_CNT1, IDX_CNT2, IDX_CNT3,
                                      IDX_RX_FLAG, IDX_TX_FLAG, IDX_INJ, 6'h3F};
    int                  failures = 0;
    int                  num_checks = 0;

    lesr_top #(.NUM_LANES(NL)) lesr_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_crc_err_i(rx_crc_err_i), .rx_lane_down_i(rx_lane_down_i),
        .rx_align_fault_i(rx_align_fault_i), .tx_fifo_underflow_i(tx_fifo_underflow_i),
        .tx_fifo_overflow_i(tx_fifo_overflow_i), .tx_crc32_i(tx_crc32_i), .tx_crc32_o(tx_crc32_o),
        .irq_o(irq_o));
    lesr_link_model #(.NUM_LANES(NL)) lesr_link_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .crc_rx_i(tx_crc32_o), .crc_tx_o(tx_crc32_i), .bad_o(bad_lanes));

    // Compare and count
    task automatic check(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack is seen
    task automatic wb_xfer(input logic we, input logic [IDX_W-1:0] idx, input logic [DAT_W-1:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        // Ack and data are taken at the rising edge, before the design updates them
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [DAT_W-1:0] exp);
        wb_xfer(1'b0, idx, DAT_ZERO);
        check(rd, exp);
    endtask

    // Expected word of one counter group from the lane model
    function automatic logic [DAT_W-1:0] grp_val(input int g);
        logic [DAT_W-1:0] v;
        v = '0;
        for (int k = 0; k < LANES_PER_GRP; k++) begin
            if (g * LANES_PER_GRP + k < NL) begin
                v[k*CNT_W+:CNT_W] = exp_cnt[g*LANES_PER_GRP+k];
            end
        end
        return v;
    endfunction

    task automatic read_groups();
        for (int g = 0; g < 4; g++) begin
            rd_chk(IDX_W'(IDX_CNT0 + g), grp_val(g));
        end
    endtask

    // Back-to-back error strobes, random lanes unless a fixed mask is given
    task automatic crc_burst(input int n, input logic [NL-1:0] fix);
        logic [NL-1:0] m;
        for (int i = 0; i < n; i++) begin
            m = (fix != '0) ? fix : NL'($urandom);
            @(posedge clk_i);
            rx_crc_err_i <= m;
            for (int l = 0; l < NL; l++) begin
                if (m[l] && exp_cnt[l] != CNT_SAT) begin
                    exp_cnt[l] = exp_cnt[l] + CNT_ONE;
                end
            end
        end
        @(posedge clk_i);
        rx_crc_err_i <= '0;
    endtask

    // One-cycle pulse on one fault source
    task automatic fire(input int s);
        @(posedge clk_i);
        case (s)
            0: rx_lane_down_i <= NL'(1) << ($urandom % NL);
            1: rx_align_fault_i <= 1'b1;
            2: tx_fifo_underflow_i <= 1'b1;
            default: tx_fifo_overflow_i <= 1'b1;
        endcase
        @(posedge clk_i);
        rx_lane_down_i      <= '0;
        rx_align_fault_i    <= 1'b0;
        tx_fifo_underflow_i <= 1'b0;
        tx_fifo_overflow_i  <= 1'b0;
    endtask

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        complete_run();
    end

    // Main sequence
    initial begin
        void'($urandom(46394));
        foreach (exp_cnt[l]) exp_cnt[l] = CNT_ZERO;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) rd_chk(regs[i], DAT_ZERO);
        $display("Test reset values done");
        crc_burst(30, '0);
        read_groups();
        wb_xfer(1'b1, IDX_CNT0, 32'hFFFF_FFFF);
        rd_chk(IDX_CNT0, grp_val(0));
        rd_chk(IDX_IRQ_STAT, 32'h0000_0001);
        wb_xfer(1'b1, IDX_LINK_RST, DAT_W'(1) << RST_CNT_CLR_BIT);
        foreach (exp_cnt[l]) exp_cnt[l] = CNT_ZERO;
        read_groups();
        crc_burst(14, ends);
        read_groups();
        crc_burst(2, ends);
        read_groups();
        $display("Test counters done");
        wb_xfer(1'b1, IDX_IRQ_EN, 32'h0000_0007);
        for (int s = 0; s < 4; s++) begin
            wb_xfer(1'b1, IDX_IRQ_CLR, 32'h0000_0007);
            fire(s);
            rd_chk(IDX_RX_FLAG, DAT_W'(s < 2));
            rd_chk(IDX_TX_FLAG, DAT_W'(s >= 2));
            rd_chk(IDX_IRQ_STAT, (s < 2) ? 32'h0000_0002 : 32'h0000_0004);
            @(negedge clk_i);
            check(DAT_W'(irq_o), 32'h0000_0001);
            wb_xfer(1'b1, IDX_LINK_RST, DAT_W'(1) << RST_CNT_CLR_BIT);
            rd_chk((s < 2) ? IDX_RX_FLAG : IDX_TX_FLAG, 32'h0000_0001);
            wb_xfer(1'b1, IDX_IRQ_EN, DAT_ZERO);
            @(negedge clk_i);
            check(DAT_W'(irq_o), DAT_ZERO);
            wb_xfer(1'b1, IDX_IRQ_EN, 32'h0000_0007);
            wb_xfer(1'b1, IDX_LINK_RST, (DAT_W'(1) << RST_RXF_CLR_BIT) | (DAT_W'(1) << RST_TXF_CLR_BIT));
            rd_chk(IDX_RX_FLAG, DAT_ZERO);
            rd_chk(IDX_TX_FLAG, DAT_ZERO);
        end
        wb_xfer(1'b1, IDX_IRQ_CLR, 32'h0000_0007);
        @(negedge clk_i);
        check(DAT_W'(irq_o), DAT_ZERO);
        $display("Test flags and interrupt done");
        for (int r = 0; r < 4; r++) begin
            mask = (r == 0) ? '1 : (r == 1) ? '0 : NL'($urandom);
            wb_xfer(1'b1, IDX_INJ, DAT_W'(mask));
            rd_chk(IDX_INJ, DAT_W'(mask));
            repeat (4) @(posedge clk_i);
            @(negedge clk_i);
            check(DAT_W'(bad_lanes), DAT_W'(mask));
        end
        $display("Test injection done");
        complete_run();
    end
endmodule
